//--- logic/tpwm_pkg.sv
// package: register map, field layout, reset values and counts for the period timer pwm block
package tpwm_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] TPWM_OFS_CONTROL    = 8'h00;
  localparam logic [7:0] TPWM_OFS_LIMIT      = 8'h04;
  localparam logic [7:0] TPWM_OFS_COUNTER    = 8'h08;
  localparam logic [7:0] TPWM_OFS_DUTY_HIGH  = 8'h0c;
  localparam logic [7:0] TPWM_OFS_MODULE_CTL = 8'h10;
  localparam logic [7:0] TPWM_OFS_ACTIVE     = 8'h14;
  localparam logic [7:0] TPWM_OFS_STATUS     = 8'h18;

  // period_timer_control field positions
  localparam int TPWM_CTL_POST_LSB = 3;
  localparam int TPWM_CTL_RUN_BIT  = 2;
  localparam int TPWM_CTL_PRE_LSB  = 0;

  // module_control field positions
  localparam int TPWM_MOD_DLOW_LSB = 4;
  localparam int TPWM_MOD_PWM_BIT  = 0;

  // status field positions
  localparam int TPWM_STA_PIN_BIT  = 0;
  localparam int TPWM_STA_SLP_BIT  = 1;

  // values after reset
  localparam logic [7:0] TPWM_RST_CONTROL = 8'h00;
  localparam logic [7:0] TPWM_RST_LIMIT   = 8'hff;
  localparam logic [7:0] TPWM_RST_COUNTER = 8'h00;
  localparam logic [7:0] TPWM_RST_DUTY    = 8'h00;
  localparam logic [1:0] TPWM_RST_DLOW    = 2'h0;

  // oscillator periods per instruction cycle
  localparam int         TPWM_OSC_PER_INSTR = 4;
  localparam logic [1:0] TPWM_PHASE_LAST    = 2'(TPWM_OSC_PER_INSTR - 1);

  // prescale select codes
  localparam logic [1:0] TPWM_PRE_DIV1 = 2'h0;
  localparam logic [1:0] TPWM_PRE_DIV4 = 2'h1;

  // prescaler terminal counts (ratio minus one)
  localparam logic [3:0] TPWM_PRE_LAST1  = 4'h0;
  localparam logic [3:0] TPWM_PRE_LAST4  = 4'h3;
  localparam logic [3:0] TPWM_PRE_LAST16 = 4'hf;

  // packed period_timer_control register
  typedef struct packed {
    logic [3:0] postscale_select;
    logic       period_timer_run;
    logic [1:0] prescale_select;
  } tpwm_ctrl_s;

  // what the prescaler hands to the counter logic
  typedef struct packed {
    logic       inc;
    logic [1:0] low_bits;
  } tpwm_tick_s;

endpackage : tpwm_pkg

//--- logic/tpwm_prescaler.sv
// prescaler: oscillator phase and instruction-rate divider feeding the period counter
`timescale 1ns/100ps
module tpwm_prescaler
  import tpwm_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       run,
  input  wire logic       sleep_mode,
  input  wire logic       clear,
  input  wire logic [1:0] prescale_select,
  // increment and time base extension
  output tpwm_tick_s      tick
);

  logic [1:0] phase_reg;
  logic [3:0] pre_reg;
  logic [3:0] pre_last;
  logic       instr_tick;

  // terminal count for the selected ratio; upper bit set means 1:16
  always_comb begin
    if (prescale_select[1]) begin
      pre_last = TPWM_PRE_LAST16;
    end else if (prescale_select == TPWM_PRE_DIV4) begin
      pre_last = TPWM_PRE_LAST4;
    end else begin
      pre_last = TPWM_PRE_LAST1;
    end
  end

  // oscillator phase within the instruction cycle; frozen in sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 2'h0;
    end else if (!sleep_mode) begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign instr_tick = (phase_reg == TPWM_PHASE_LAST) && !sleep_mode;

  // instruction-rate divider, counts only while the timer runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 4'h0;
    end else if (clear) begin
      pre_reg <= 4'h0;
    end else if (run && instr_tick) begin
      pre_reg <= (pre_reg >= pre_last) ? 4'h0 : pre_reg + 4'h1;
    end
  end

  // low time base bits: oscillator phase at 1:1, else prescaler bits
  always_comb begin
    tick.inc = run && instr_tick && (pre_reg >= pre_last);
    if (prescale_select == TPWM_PRE_DIV1) begin
      tick.low_bits = phase_reg;
    end else if (prescale_select[1]) begin
      tick.low_bits = pre_reg[3:2];
    end else begin
      tick.low_bits = pre_reg[1:0];
    end
  end

endmodule : tpwm_prescaler

//--- logic/tpwm_top.sv
// top: apb register file, period counter, postscaler and double-buffered pwm output
`timescale 1ns/100ps
module tpwm_top
  import tpwm_pkg::*;
#(
  parameter int DUTY_W = 10
)
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // device state
  input  wire logic        sleep_mode,
  // pwm pin and postscaled period event
  output logic             pulse_output_pin,
  output logic             postscale_tick
);

  // register state
  tpwm_ctrl_s        ctrl_reg;
  logic [7:0]        period_limit_reg;
  logic [7:0]        period_counter_reg;
  logic [7:0]        duty_high_bits_reg;
  logic [1:0]        duty_low_bits_reg;
  logic              pwm_mode_reg;
  logic [7:0]        active_duty_buffer_reg;
  logic [1:0]        active_low_latch_reg;
  logic [3:0]        post_count_reg;
  logic              pin_reg;
  logic              post_tick_reg;

  // bus handshake state
  logic              pready_reg;
  logic              pslverr_reg;
  logic [31:0]       prdata_reg;
  logic [31:0]       rdata_next;
  logic              addr_hit;

  // decoded strobes
  logic              wr_en;
  logic              wr_ctrl;
  logic              wr_limit;
  logic              wr_counter;
  logic              wr_duty;
  logic              wr_modctl;
  logic              wr_active;

  // timer signals
  tpwm_tick_s        tick;
  logic              period_match;
  logic              boundary;
  logic [DUTY_W-1:0] time_base;
  logic [DUTY_W-1:0] active_duty;
  logic [DUTY_W-1:0] written_duty;

  // pwm level and its compares
  logic              level_reg;
  logic              duty_hit;
  logic              duty_nonzero;

  // true for an address that holds a register
  function automatic logic addr_mapped(input logic [7:0] a);
    if (a == TPWM_OFS_CONTROL) begin
      return 1'b1;
    end else if (a == TPWM_OFS_LIMIT) begin
      return 1'b1;
    end else if (a == TPWM_OFS_COUNTER) begin
      return 1'b1;
    end else if (a == TPWM_OFS_DUTY_HIGH) begin
      return 1'b1;
    end else if (a == TPWM_OFS_MODULE_CTL) begin
      return 1'b1;
    end else if (a == TPWM_OFS_ACTIVE) begin
      return 1'b1;
    end else if (a == TPWM_OFS_STATUS) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : addr_mapped

  // a write lands only at the edge where the master sees pready high
  assign wr_en      = psel && penable && pwrite && pready_reg;
  assign wr_ctrl    = wr_en && (paddr == TPWM_OFS_CONTROL);
  assign wr_limit   = wr_en && (paddr == TPWM_OFS_LIMIT);
  assign wr_counter = wr_en && (paddr == TPWM_OFS_COUNTER);
  assign wr_duty    = wr_en && (paddr == TPWM_OFS_DUTY_HIGH);
  assign wr_modctl  = wr_en && (paddr == TPWM_OFS_MODULE_CTL);
  assign wr_active  = wr_en && (paddr == TPWM_OFS_ACTIVE) && !pwm_mode_reg;
  assign addr_hit   = addr_mapped(paddr);

  // prescaler; a counter or control write restarts it
  // sleep freezes the phase too, so the time base resumes where it stopped
  tpwm_prescaler u_prescaler (
    .pclk            (pclk),
    .presetn         (presetn),
    .run             (ctrl_reg.period_timer_run),
    .sleep_mode      (sleep_mode),
    .clear           (wr_counter || wr_ctrl),
    .prescale_select (ctrl_reg.prescale_select),
    .tick            (tick)
  );

  // period boundary is the increment that follows counter equal limit;
  // checking on the increment, not on equality alone, makes the limit value
  // itself a full step of the period
  assign period_match = (period_counter_reg == period_limit_reg);
  assign boundary     = tick.inc && period_match;

  // 10-bit views of the time base and the duty values
  // at 1:1 the low bits are the oscillator phase, so no resolution is lost
  assign time_base    = {period_counter_reg, tick.low_bits};
  assign active_duty  = {active_duty_buffer_reg, active_low_latch_reg};
  assign written_duty = {duty_high_bits_reg, duty_low_bits_reg};

  // compare shared by the level and the pin flop; zero-duty decode for the level flop
  assign duty_hit     = (time_base == active_duty);
  assign duty_nonzero = (written_duty != '0);

  // apb handshake: one wait state, answer registered
  // the fixed wait state gives the read mux a full cycle before the answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
    end
  end

  // unmapped addresses answer with an error and zero data
  // a write to an unmapped address changes nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= psel && penable && !pready_reg && !addr_hit;
    end
  end

  // read mux; unused upper bits read as zero
  // a read has no side effect on any register
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (paddr == TPWM_OFS_CONTROL) begin
      rdata_next[7:0] = {1'b0, ctrl_reg};
    end else if (paddr == TPWM_OFS_LIMIT) begin
      rdata_next[7:0] = period_limit_reg;
    end else if (paddr == TPWM_OFS_COUNTER) begin
      rdata_next[7:0] = period_counter_reg;
    end else if (paddr == TPWM_OFS_DUTY_HIGH) begin
      rdata_next[7:0] = duty_high_bits_reg;
    end else if (paddr == TPWM_OFS_MODULE_CTL) begin
      rdata_next[TPWM_MOD_DLOW_LSB +: 2] = duty_low_bits_reg;
      rdata_next[TPWM_MOD_PWM_BIT]       = pwm_mode_reg;
    end else if (paddr == TPWM_OFS_ACTIVE) begin
      rdata_next[7:0] = active_duty_buffer_reg;
    end else if (paddr == TPWM_OFS_STATUS) begin
      rdata_next[TPWM_STA_PIN_BIT] = pin_reg;
      rdata_next[TPWM_STA_SLP_BIT] = sleep_mode;
    end
  end

  // read data captured with pready so it is stable in the answer cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && penable && !pready_reg && !pwrite) begin
      prdata_reg <= rdata_next;
    end
  end

  // period_timer_control
  // a control write also restarts the prescaler and the postscaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= tpwm_ctrl_s'(TPWM_RST_CONTROL[6:0]);
    end else if (wr_ctrl) begin
      ctrl_reg.postscale_select <= pwdata[TPWM_CTL_POST_LSB +: 4];
      ctrl_reg.period_timer_run <= pwdata[TPWM_CTL_RUN_BIT];
      ctrl_reg.prescale_select  <= pwdata[TPWM_CTL_PRE_LSB +: 2];
    end
  end

  // period_limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_limit_reg <= TPWM_RST_LIMIT;
    end else if (wr_limit) begin
      period_limit_reg <= pwdata[7:0];
    end
  end

  // period counter; a software write wins over a coinciding increment
  // a value parked above the limit runs on to the wrap before the next match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_counter_reg <= TPWM_RST_COUNTER;
    end else if (wr_counter) begin
      period_counter_reg <= pwdata[7:0];
    end else if (boundary) begin
      period_counter_reg <= 8'h00;
    end else if (tick.inc) begin
      period_counter_reg <= period_counter_reg + 8'h01;
    end
  end

  // software duty fields, writable at any moment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_high_bits_reg <= TPWM_RST_DUTY;
    end else if (wr_duty) begin
      duty_high_bits_reg <= pwdata[7:0];
    end
  end

  // module control: low duty bits and pwm mode
  // pwm mode off parks the pin low and makes the active buffer writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_low_bits_reg <= TPWM_RST_DLOW;
      pwm_mode_reg      <= 1'b0;
    end else if (wr_modctl) begin
      duty_low_bits_reg <= pwdata[TPWM_MOD_DLOW_LSB +: 2];
      pwm_mode_reg      <= pwdata[TPWM_MOD_PWM_BIT];
    end
  end

  // active buffer reloads only at the boundary, so mid-period writes never glitch
  // a software write lands only while pwm mode is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_duty_buffer_reg <= TPWM_RST_DUTY;
    end else if (boundary) begin
      active_duty_buffer_reg <= duty_high_bits_reg;
    end else if (wr_active) begin
      active_duty_buffer_reg <= pwdata[7:0];
    end
  end

  // hidden low latch, never visible to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_low_latch_reg <= TPWM_RST_DLOW;
    end else if (boundary) begin
      active_low_latch_reg <= duty_low_bits_reg;
    end
  end

  // pwm level of the current time base step: set at the boundary, cleared
  // on the duty match; a duty past the period never matches and leaves the
  // level high, and a zero duty is never set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= 1'b0;
    end else if (!pwm_mode_reg) begin
      level_reg <= 1'b0;
    end else if (sleep_mode) begin
      level_reg <= level_reg;
    end else if (boundary) begin
      level_reg <= duty_nonzero;
    end else if (duty_hit) begin
      level_reg <= 1'b0;
    end
  end

  // output flop: trails the time base by one clock and is already low in the
  // step whose time base equals the duty, so the high time is exactly the
  // duty; a flop set by the match alone would stretch every pulse by a clock;
  // sleep holds it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg <= 1'b0;
    end else if (!pwm_mode_reg) begin
      pin_reg <= 1'b0;
    end else if (sleep_mode) begin
      pin_reg <= pin_reg;
    end else begin
      pin_reg <= level_reg && !duty_hit;
    end
  end

  // postscaler counts boundaries, pulses once every select plus one
  // a control write restarts the count, so a new ratio starts clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_count_reg <= 4'h0;
    end else if (wr_ctrl) begin
      post_count_reg <= 4'h0;
    end else if (boundary) begin
      if (post_count_reg >= ctrl_reg.postscale_select) begin
        post_count_reg <= 4'h0;
      end else begin
        post_count_reg <= post_count_reg + 4'h1;
      end
    end
  end

  // one-cycle postscaled event
  // it trails the boundary by one clock, in step with the level flop and one clock ahead of the pin flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_tick_reg <= 1'b0;
    end else begin
      post_tick_reg <= boundary && !wr_ctrl &&
                       (post_count_reg >= ctrl_reg.postscale_select);
    end
  end

  // outputs straight from flops
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign prdata           = prdata_reg;
  assign pulse_output_pin = pin_reg;
  assign postscale_tick   = post_tick_reg;

endmodule : tpwm_top

//--- verification/tpwm_top_sva.sv
// checker: apb handshake, read data and pwm pin relations at the top ports
`timescale 1ns/100ps
module tpwm_top_sva
  import tpwm_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // device state and pwm outputs
  input wire logic        sleep_mode,
  input wire logic        pulse_output_pin,
  input wire logic        postscale_tick
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // exactly one wait state after the first access cycle
  a_ready_one_wait: assert property (psel && penable && !$past(penable) |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_ready_cause: assert property (pready |-> psel && penable && $past(psel && penable)) else $error("pready unasked");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  // addresses above the status register answer with an error and zero read data
  a_err_unmapped: assert property (pready && paddr > TPWM_OFS_STATUS |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped not refused");
  a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper data set");
  a_ctl_top_zero: assert property (pready && !pwrite && paddr == TPWM_OFS_CONTROL |-> !prdata[7])
    else $error("control bit 7 set");
  // read data only moves when a read is answered
  a_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite) else $error("prdata moved");
  a_sleep_freeze: assert property (sleep_mode |=> $stable(pulse_output_pin))
    else $error("pin moved in sleep");
  // shortest period is four clocks, so the event is a single cycle
  a_tick_pulse: assert property (postscale_tick |=> !postscale_tick)
    else $error("tick held");
endmodule : tpwm_top_sva

//--- verification/tpwm_load_model.sv
// load model: counts high cycles, rising edges and period events in a window
`timescale 1ns/100ps
module tpwm_load_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // observed pin and period event
  input  wire logic        pin,
  input  wire logic        tick,
  // measurement request and result
  input  wire logic        arm,
  input  wire logic [15:0] win,
  output logic [15:0]      hi_cnt,
  output logic [15:0]      rise_cnt,
  output logic [15:0]      tick_cnt,
  output logic             done
);
  logic [15:0] left_reg;
  logic        prev_reg;

  // a window that is a whole number of periods makes the counts phase independent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_reg <= 16'h0;
      prev_reg <= 1'b0;
      hi_cnt   <= 16'h0;
      rise_cnt <= 16'h0;
      tick_cnt <= 16'h0;
      done     <= 1'b0;
    end else begin
      prev_reg <= pin;
      done     <= 1'b0;
      if (arm) begin
        left_reg <= win;
        hi_cnt   <= 16'h0;
        rise_cnt <= 16'h0;
        tick_cnt <= 16'h0;
      end else if (left_reg != 16'h0) begin
        left_reg <= left_reg - 16'h1;
        hi_cnt   <= hi_cnt + 16'(pin);
        rise_cnt <= rise_cnt + 16'(pin & ~prev_reg);
        tick_cnt <= tick_cnt + 16'(tick);
        done     <= (left_reg == 16'h1);
      end
    end
  end
endmodule : tpwm_load_model

//--- verification/tb_tpwm_top.sv
// testbench: apb register checks and measured pwm waveforms of the period timer
`timescale 1ns/100ps
module tb_tpwm_top;
  import tpwm_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        sleep_mode = 1'b0;
  logic        arm = 1'b0;
  logic [15:0] win = 16'h0;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        pin;
  logic        tick;
  logic        done;
  logic [15:0] hi_cnt;
  logic [15:0] rise_cnt;
  logic [15:0] tick_cnt;
  logic [32:0] rd_q[$];
  logic [47:0] pw_q[$];
  int          miscompares = 0;
  int          checks = 0;
  logic [31:0] rs = 32'd55190;
  int          rows[7][4] = '{'{0,0,1,4}, '{1,1,3,5}, '{2,3,0,3}, '{3,0,2,7}, '{0,0,3,0}, '{0,1,1,9}, '{1,0,0,4}};

  always #4 pclk = ~pclk;

  tpwm_top i_tpwm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .pulse_output_pin(pin), .postscale_tick(tick));
  tpwm_load_model i_tpwm_load_model (.pclk(pclk), .presetn(presetn), .pin(pin), .tick(tick), .arm(arm),
    .win(win), .hi_cnt(hi_cnt), .rise_cnt(rise_cnt), .tick_cnt(tick_cnt), .done(done));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction : xs

  task automatic end_sim;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic cmp_rd(input logic [32:0] e, input logic [32:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH apb_read exp %h seen %h", e, s);
    end
  endtask : cmp_rd

  task automatic cmp_pw(input logic [47:0] e, input logic [47:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH pwm_high_rise_tick exp %h seen %h", e, s);
    end
  endtask : cmp_pw

  // apb master: hold the request until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask : rd

  // program one waveform, let two periods settle, then measure four periods
  task automatic pwm_run(input logic [1:0] pre, input logic [3:0] post, input logic [7:0] lim, input logic [9:0] d);
    int r;
    int p;
    logic [15:0] eh;
    logic [15:0] er;
    r = (pre == 2'h0) ? 1 : (pre == 2'h1) ? 4 : 16;
    p = (lim + 1) * 4 * r;
    eh = (d == 0) ? 16'h0 : (d >= 4 * (lim + 1)) ? 16'(4 * p) : 16'(4 * d * r);
    er = (d == 0 || d >= 4 * (lim + 1)) ? 16'h0 : 16'h4;
    apb(TPWM_OFS_CONTROL, 1'b1, 32'h0);
    apb(TPWM_OFS_LIMIT, 1'b1, {24'h0, lim});
    apb(TPWM_OFS_DUTY_HIGH, 1'b1, {24'h0, d[9:2]});
    apb(TPWM_OFS_MODULE_CTL, 1'b1, {26'h0, d[1:0], 4'h1});
    apb(TPWM_OFS_COUNTER, 1'b1, 32'h0);
    apb(TPWM_OFS_CONTROL, 1'b1, {25'h0, post, 1'b1, pre});
    repeat (2 * p + 4) @(posedge pclk);
    pw_q.push_back({eh, er, 16'(4 / (post + 1))});
    win <= 16'(4 * p);
    arm <= 1'b1;
    @(posedge pclk);
    arm <= 1'b0;
    repeat (4 * p + 4) @(posedge pclk);
  endtask : pwm_run

  // result watcher: oldest note against each answered read and each finished window
  always @(posedge pclk) begin
    if (psel && pready === 1'b1 && pwrite === 1'b0) cmp_rd(rd_q.pop_front(), {pslverr, prdata});
    if (done === 1'b1) cmp_pw(pw_q.pop_front(), {hi_cnt, rise_cnt, tick_cnt});
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(TPWM_OFS_CONTROL, {25'h0, TPWM_RST_CONTROL});
    rd(TPWM_OFS_LIMIT, {25'h0, TPWM_RST_LIMIT});
    rd(TPWM_OFS_COUNTER, {25'h0, TPWM_RST_COUNTER});
    rd(TPWM_OFS_ACTIVE, 33'h0);
    rd(8'h1c, {1'b1, 32'h0});
    apb(TPWM_OFS_CONTROL, 1'b1, 32'hff);
    rd(TPWM_OFS_CONTROL, 33'h7f);
    // duty double buffer: stopped timer keeps the old active value
    pwm_run(2'h0, 4'h0, 8'h03, 10'd9);
    apb(TPWM_OFS_CONTROL, 1'b1, 32'h0);
    apb(TPWM_OFS_DUTY_HIGH, 1'b1, 32'h05);
    rd(TPWM_OFS_ACTIVE, 33'h2);
    apb(TPWM_OFS_ACTIVE, 1'b1, 32'h55);
    rd(TPWM_OFS_ACTIVE, 33'h2);
    apb(TPWM_OFS_CONTROL, 1'b1, 32'h4);
    repeat (40) @(posedge pclk);
    rd(TPWM_OFS_ACTIVE, 33'h5);
    rd(TPWM_OFS_MODULE_CTL, 33'h11);
    // counter frozen while stopped and while asleep
    apb(TPWM_OFS_CONTROL, 1'b1, 32'h0);
    apb(TPWM_OFS_COUNTER, 1'b1, 32'h05);
    repeat (40) @(posedge pclk);
    rd(TPWM_OFS_COUNTER, 33'h05);
    sleep_mode <= 1'b1;
    apb(TPWM_OFS_CONTROL, 1'b1, 32'h4);
    repeat (40) @(posedge pclk);
    rd(TPWM_OFS_COUNTER, 33'h05);
    sleep_mode <= 1'b0;
    for (int i = 0; i < 7; i++) pwm_run(2'(rows[i][0]), 4'(rows[i][1]), 8'(rows[i][2]), 10'(rows[i][3]));
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      pwm_run(rs[4:3], 4'((1 << (rs[6:5] % 3)) - 1), {5'h0, rs[2:0]}, 10'(rs[31:16] % (4 * (rs[2:0] + 1) + 2)));
    end
    end_sim;
  end

  // watchdog: the whole sequence needs well under this many clocks
  initial begin
    repeat (95000) @(posedge pclk);
    miscompares++;
    end_sim;
  end
endmodule : tb_tpwm_top

bind tpwm_top tpwm_top_sva i_tpwm_top_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .sleep_mode(sleep_mode), .pulse_output_pin(pulse_output_pin), .postscale_tick(postscale_tick));
